// file: dv/bws_sec_model.sv
// Secondary side event source for the bridge window and status bank
`timescale 1ns/1ns
module bws_sec_model (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    // Requests from the bench
    input  wire logic [4:0] ev_req_i,
    // Events: cpl, wr, tlp, fatal, nonfatal
    output logic      [4:0] ev_o
);
    logic [4:0] next_ev;

    always_comb begin
        next_ev = ev_req_i;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev_o <= 5'h00;
        end else begin
            ev_o <= next_ev;
        end
    end
endmodule

// file: dv/test_bridge_window_status_regs.sv
// Self-checking bench for the bridge window and status bank
`timescale 1ns/1ns
module test_bridge_window_status_regs;
    import bws_pkg::*;
    logic              mclk_i = 1'b0;
    logic              arst_n_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = 4'hF;
    logic [DATA_W-1:0] avs_readdata_o;
    logic              avs_waitrequest_o;
    logic [4:0]        ev_req = 5'h00;
    logic [4:0]        ev;
    logic [31:0]       io_addr_i = '0;
    logic [31:0]       mem_addr_i = '0;
    logic              io_fwd_o;
    logic              mem_fwd_o;
    logic              irq_o;
    logic [31:0]       exp_flag [5] = '{32'h100, 32'h100, 32'h8000, 32'h4000, 32'h4000};
    int                errors = 0;
    int                check_count = 0;
    int                cycles = 0;

    bws_sec_model i_sec (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ev_req_i(ev_req), .ev_o(ev));

    bws_regs i_dut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sec_poison_cpl_i(ev[0]), .sec_poison_wr_i(ev[1]), .sec_poison_tlp_i(ev[2]),
        .sec_err_fatal_i(ev[3]), .sec_err_nonfatal_i(ev[4]), .io_addr_i(io_addr_i),
        .mem_addr_i(mem_addr_i), .io_fwd_o(io_fwd_o), .mem_fwd_o(mem_fwd_o), .irq_o(irq_o)
    );

    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        avs_address_i <= {idx, 2'h0};
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        check(what, exp, q);
    endtask

    task automatic fire(input logic [4:0] v);
        @(posedge mclk_i);
        ev_req <= v;
        @(posedge mclk_i);
        ev_req <= 5'h00;
        @(posedge mclk_i);
    endtask

    task automatic win(input logic [31:0] ia, input logic [31:0] ma, input logic ie, input logic me);
        @(posedge mclk_i);
        io_addr_i <= ia;
        mem_addr_i <= ma;
        @(posedge mclk_i);
        @(negedge mclk_i);
        check("io_fwd_o", {31'h0, ie}, {31'h0, io_fwd_o});
        check("mem_fwd_o", {31'h0, me}, {31'h0, mem_fwd_o});
    endtask

    task automatic t_access;
        rd("io_window_limit", IDX_IO_LIMIT, 32'h1);
        rd("secondary_side_status", IDX_SEC_STATUS, 32'h0);
        rd("memory_window_base", IDX_MEM_BASE, 32'hFFF0);
        wr(IDX_IO_LIMIT, 32'hFFFFFFFE);
        rd("io_window_limit", IDX_IO_LIMIT, 32'hF1);
        wr(IDX_IO_BASE, 32'h0);
        rd("io_window_limit cap", IDX_IO_LIMIT, 32'hF0);
        wr(IDX_MEM_BASE, 32'hFFFFFFFF);
        rd("memory_window_base", IDX_MEM_BASE, 32'hFFF0);
        avs_byteenable_i <= 4'h2;
        wr(IDX_MEM_BASE, 32'h0);
        avs_byteenable_i <= 4'hF;
        rd("memory_window_base lanes", IDX_MEM_BASE, 32'hF0);
        wr(IDX_SEC_STATUS, 32'hFFFFFFFF);
        rd("secondary_side_status", IDX_SEC_STATUS, 32'h0);
        wr(8'h3F, 32'hFFFFFFFF);
        rd("unmapped", 8'h3F, 32'h0);
    endtask

    task automatic t_events;
        wr(IDX_BRIDGE_CTRL, 32'h0);
        fire(5'h1B);
        rd("status disabled", IDX_SEC_STATUS, 32'h0);
        wr(IDX_BRIDGE_CTRL, 32'h3);
        for (int i = 0; i < 5; i++) begin
            fire(5'h01 << i);
            rd("event flag", IDX_SEC_STATUS, exp_flag[i]);
            wr(IDX_SEC_STATUS, exp_flag[i]);
            rd("flag cleared", IDX_SEC_STATUS, 32'h0);
        end
    endtask

    task automatic t_irq;
        wr(IDX_IRQ_STATUS, 32'h7);
        wr(IDX_IRQ_MASK, 32'h4);
        fire(5'h04);
        rd("irq status", IDX_IRQ_STATUS, 32'h4);
        check("irq_o set", 32'h1, {31'h0, irq_o});
        wr(IDX_IRQ_MASK, 32'h0);
        repeat (2) @(negedge mclk_i);
        check("irq_o masked", 32'h0, {31'h0, irq_o});
        wr(IDX_IRQ_MASK, 32'h4);
        wr(IDX_IRQ_STATUS, 32'h4);
        repeat (2) @(negedge mclk_i);
        check("irq_o cleared", 32'h0, {31'h0, irq_o});
        wr(IDX_SEC_STATUS, 32'h8000);
    endtask

    task automatic t_window;
        wr(IDX_IO_BASE, 32'h21);
        wr(IDX_IO_LIMIT, 32'h30);
        wr(IDX_MEM_BASE, 32'h1000);
        wr(IDX_MEM_LIMIT, 32'h1010);
        win(32'h1FFF, 32'h0FFFFFFF, 1'b0, 1'b0);
        win(32'h2000, 32'h10000000, 1'b1, 1'b1);
        win(32'h3FFF, 32'h101FFFFF, 1'b1, 1'b1);
        win(32'h4000, 32'h10200000, 1'b0, 1'b0);
        win(32'h12000, 32'h10100000, 1'b0, 1'b1);
        wr(IDX_IO_BASE, 32'h41);
        wr(IDX_MEM_BASE, 32'h1020);
        win(32'h3000, 32'h10100000, 1'b0, 1'b0);
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_access();
        t_events();
        t_irq();
        t_window();
        test_done();
    end
endmodule

// file: rtl/bws_pkg.sv
// Constants, field layouts and helpers for the bridge window and status registers
package bws_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_IO_BASE     = 8'h1C;
    localparam logic [IDX_W-1:0] IDX_IO_LIMIT    = 8'h1D;
    localparam logic [IDX_W-1:0] IDX_SEC_STATUS  = 8'h1E;
    localparam logic [IDX_W-1:0] IDX_MEM_BASE    = 8'h20;
    localparam logic [IDX_W-1:0] IDX_MEM_LIMIT   = 8'h22;
    localparam logic [IDX_W-1:0] IDX_BRIDGE_CTRL = 8'h40;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 8'h41;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 8'h42;

    // Field positions
    localparam int IO_CAP_BIT      = 0;
    localparam int IO_FIELD_LSB    = 4;
    localparam int IO_FIELD_MSB    = 7;
    localparam int MEM_FIELD_LSB   = 4;
    localparam int MEM_FIELD_MSB   = 15;
    localparam int SEC_MPOISON_BIT = 8;
    localparam int SEC_RSE_BIT     = 14;
    localparam int SEC_DPE_BIT     = 15;
    localparam int BRIDGE_CONTROL_PARITY_ERROR_RESPONSE_ENABLE_BIT  = 0;
    localparam int BRIDGE_CONTROL_SYSTEM_ERROR_REPORT_ENABLE_BIT  = 1;
    localparam int IRQ_W           = 3;
    localparam int IRQ_MPOISON_BIT = 0;
    localparam int IRQ_RSE_BIT     = 1;
    localparam int IRQ_DPE_BIT     = 2;

    // Reset values
    localparam logic        IO_CAP_RST    = 1'h1;
    localparam logic [3:0]  IO_BASE_RST   = 4'hF;
    localparam logic [3:0]  IO_LIMIT_RST  = 4'h0;
    localparam logic [11:0] MEM_BASE_RST  = 12'hFFF;
    localparam logic [11:0] MEM_LIMIT_RST = 12'h000;
    localparam logic [1:0]  BRIDGE_CONTROL_RST      = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

    // Window address fills
    localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;
    localparam logic [11:0] IO_LOW_ZERO   = 12'h000;
    localparam logic [11:0] IO_LOW_ONES   = 12'hFFF;
    localparam logic [19:0] MEM_LOW_ZERO  = 20'h00000;
    localparam logic [19:0] MEM_LOW_ONES  = 20'hFFFFF;

    // Register index to byte address
    function automatic logic [ADDR_W-1:0] idx_addr(input logic [IDX_W-1:0] idx);
        return {idx, 2'h0};
    endfunction
endpackage

// file: rtl/bws_regs.sv
// Bridge window and secondary status register bank with Avalon-MM slave
`timescale 1ns/1ns
module bws_regs
    import bws_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Secondary side events
    input  wire logic              sec_poison_cpl_i,
    input  wire logic              sec_poison_wr_i,
    input  wire logic              sec_poison_tlp_i,
    input  wire logic              sec_err_fatal_i,
    input  wire logic              sec_err_nonfatal_i,
    // Forwarding checks
    input  wire logic [31:0]       io_addr_i,
    input  wire logic [31:0]       mem_addr_i,
    output logic                   io_fwd_o,
    output logic                   mem_fwd_o,
    // Interrupt
    output logic                   irq_o
);
    // Bus handshake
    logic              ack;
    logic              next_ack;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] rd_val;
    logic              req;
    logic              wr_now;

    // Register state
    logic              io_width_capability;
    logic [3:0]        io_window_base;
    logic [3:0]        io_window_limit;
    logic [11:0]       memory_window_base;
    logic [11:0]       memory_window_limit;
    logic [1:0]        bridge_control;
    logic              master_poison_flag;
    logic              received_system_error_flag;
    logic              detected_poison_flag;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic              irq;
    logic              next_io_width_capability;
    logic [3:0]        next_io_window_base;
    logic [3:0]        next_io_window_limit;
    logic [11:0]       next_memory_window_base;
    logic [11:0]       next_memory_window_limit;
    logic [1:0]        next_bridge_control;
    logic              next_master_poison_flag;
    logic              next_received_system_error_flag;
    logic              next_detected_poison_flag;
    logic [IRQ_W-1:0]  next_irq_status;
    logic [IRQ_W-1:0]  next_irq_mask;
    logic              next_irq;

    // Event decode
    logic              parity_error_response_enable;
    logic              system_error_report_enable;
    logic              set_mpoison;
    logic              set_rse;
    logic              set_dpe;
    logic [IRQ_W-1:0]  irq_set;

    // Write strobes per register
    function automatic logic wr_hit(input logic [IDX_W-1:0] idx, input logic en, input logic [ADDR_W-1:0] a);
        return en && (a == idx_addr(idx));
    endfunction

    assign req    = avs_read_i || avs_write_i;
    assign wr_now = avs_write_i && ack;
    assign avs_waitrequest_o = req && !ack;
    assign avs_readdata_o    = rdata;

    assign parity_error_response_enable = bridge_control[BRIDGE_CONTROL_PARITY_ERROR_RESPONSE_ENABLE_BIT];
    assign system_error_report_enable   = bridge_control[BRIDGE_CONTROL_SYSTEM_ERROR_REPORT_ENABLE_BIT];
    assign set_mpoison = parity_error_response_enable && (sec_poison_cpl_i || sec_poison_wr_i);
    assign set_rse     = system_error_report_enable && (sec_err_fatal_i || sec_err_nonfatal_i);
    assign set_dpe     = sec_poison_tlp_i;
    assign irq_set     = {set_dpe, set_rse, set_mpoison};

    // Read mux
    always_comb begin
        rd_val = '0;
        unique case (avs_address_i)
            idx_addr(IDX_IO_BASE): begin
                rd_val[IO_FIELD_MSB:IO_FIELD_LSB] = io_window_base;
                rd_val[IO_CAP_BIT]                = io_width_capability;
            end
            idx_addr(IDX_IO_LIMIT): begin
                rd_val[IO_FIELD_MSB:IO_FIELD_LSB] = io_window_limit;
                rd_val[IO_CAP_BIT]                = io_width_capability;
            end
            idx_addr(IDX_SEC_STATUS): begin
                rd_val[SEC_MPOISON_BIT] = master_poison_flag;
                rd_val[SEC_RSE_BIT]     = received_system_error_flag;
                rd_val[SEC_DPE_BIT]     = detected_poison_flag;
            end
            idx_addr(IDX_MEM_BASE): begin
                rd_val[MEM_FIELD_MSB:MEM_FIELD_LSB] = memory_window_base;
            end
            idx_addr(IDX_MEM_LIMIT): begin
                rd_val[MEM_FIELD_MSB:MEM_FIELD_LSB] = memory_window_limit;
            end
            idx_addr(IDX_BRIDGE_CTRL): begin
                rd_val[1:0] = bridge_control;
            end
            idx_addr(IDX_IRQ_STATUS): begin
                rd_val[IRQ_W-1:0] = irq_status;
            end
            idx_addr(IDX_IRQ_MASK): begin
                rd_val[IRQ_W-1:0] = irq_mask;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // Bus handshake next state
    always_comb begin
        next_ack   = req && !ack;
        next_rdata = rdata;
        if (avs_read_i && !ack) begin
            next_rdata = rd_val;
        end
    end

    // Register next state
    always_comb begin
        next_io_width_capability        = io_width_capability;
        next_io_window_base             = io_window_base;
        next_io_window_limit            = io_window_limit;
        next_memory_window_base         = memory_window_base;
        next_memory_window_limit        = memory_window_limit;
        next_bridge_control             = bridge_control;
        next_irq_mask                   = irq_mask;
        next_master_poison_flag         = master_poison_flag;
        next_received_system_error_flag = received_system_error_flag;
        next_detected_poison_flag       = detected_poison_flag;
        next_irq_status                 = irq_status;
        if (wr_hit(IDX_IO_BASE, wr_now, avs_address_i) && avs_byteenable_i[0]) begin
            next_io_width_capability = avs_writedata_i[IO_CAP_BIT];
            next_io_window_base      = avs_writedata_i[IO_FIELD_MSB:IO_FIELD_LSB];
        end
        if (wr_hit(IDX_IO_LIMIT, wr_now, avs_address_i) && avs_byteenable_i[0]) begin
            next_io_window_limit = avs_writedata_i[IO_FIELD_MSB:IO_FIELD_LSB];
        end
        if (wr_hit(IDX_MEM_BASE, wr_now, avs_address_i)) begin
            if (avs_byteenable_i[0]) begin
                next_memory_window_base[3:0] = avs_writedata_i[7:MEM_FIELD_LSB];
            end
            if (avs_byteenable_i[1]) begin
                next_memory_window_base[11:4] = avs_writedata_i[MEM_FIELD_MSB:8];
            end
        end
        if (wr_hit(IDX_MEM_LIMIT, wr_now, avs_address_i)) begin
            if (avs_byteenable_i[0]) begin
                next_memory_window_limit[3:0] = avs_writedata_i[7:MEM_FIELD_LSB];
            end
            if (avs_byteenable_i[1]) begin
                next_memory_window_limit[11:4] = avs_writedata_i[MEM_FIELD_MSB:8];
            end
        end
        if (wr_hit(IDX_BRIDGE_CTRL, wr_now, avs_address_i) && avs_byteenable_i[0]) begin
            next_bridge_control = avs_writedata_i[1:0];
        end
        if (wr_hit(IDX_IRQ_MASK, wr_now, avs_address_i) && avs_byteenable_i[0]) begin
            next_irq_mask = avs_writedata_i[IRQ_W-1:0];
        end
        // Write one clears, a same-cycle set wins
        if (wr_hit(IDX_SEC_STATUS, wr_now, avs_address_i) && avs_byteenable_i[1]) begin
            next_master_poison_flag         = master_poison_flag && !avs_writedata_i[SEC_MPOISON_BIT];
            next_received_system_error_flag = received_system_error_flag && !avs_writedata_i[SEC_RSE_BIT];
            next_detected_poison_flag       = detected_poison_flag && !avs_writedata_i[SEC_DPE_BIT];
        end
        if (wr_hit(IDX_IRQ_STATUS, wr_now, avs_address_i) && avs_byteenable_i[0]) begin
            next_irq_status = irq_status & ~avs_writedata_i[IRQ_W-1:0];
        end
        next_master_poison_flag         = next_master_poison_flag || set_mpoison;
        next_received_system_error_flag = next_received_system_error_flag || set_rse;
        next_detected_poison_flag       = next_detected_poison_flag || set_dpe;
        next_irq_status                 = next_irq_status | irq_set;
        next_irq                        = |(irq_status & irq_mask);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_width_capability        <= IO_CAP_RST;
            io_window_base             <= IO_BASE_RST;
            io_window_limit            <= IO_LIMIT_RST;
            memory_window_base         <= MEM_BASE_RST;
            memory_window_limit        <= MEM_LIMIT_RST;
            bridge_control             <= BRIDGE_CONTROL_RST;
            master_poison_flag         <= 1'b0;
            received_system_error_flag <= 1'b0;
            detected_poison_flag       <= 1'b0;
            irq_status                 <= IRQ_RST;
            irq_mask                   <= IRQ_RST;
            irq                        <= 1'b0;
        end else begin
            io_width_capability        <= next_io_width_capability;
            io_window_base             <= next_io_window_base;
            io_window_limit            <= next_io_window_limit;
            memory_window_base         <= next_memory_window_base;
            memory_window_limit        <= next_memory_window_limit;
            bridge_control             <= next_bridge_control;
            master_poison_flag         <= next_master_poison_flag;
            received_system_error_flag <= next_received_system_error_flag;
            detected_poison_flag       <= next_detected_poison_flag;
            irq_status                 <= next_irq_status;
            irq_mask                   <= next_irq_mask;
            irq                        <= next_irq;
        end
    end

    assign irq_o = irq;

    // Forwarding windows
    bws_win_if io_win ();
    bws_win_if mem_win ();

    assign io_win.addr  = io_addr_i;
    assign io_win.low   = {IO_UPPER_ZERO, io_window_base, IO_LOW_ZERO};
    assign io_win.high  = {IO_UPPER_ZERO, io_window_limit, IO_LOW_ONES};
    assign mem_win.addr = mem_addr_i;
    assign mem_win.low  = {memory_window_base, MEM_LOW_ZERO};
    assign mem_win.high = {memory_window_limit, MEM_LOW_ONES};

    bws_win_cmp u_io_cmp (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .win      (io_win.cmp)
    );

    bws_win_cmp u_mem_cmp (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .win      (mem_win.cmp)
    );

    assign io_fwd_o  = io_win.hit;
    assign mem_fwd_o = mem_win.hit;

    // Checks
    chk_iolim_cap_mirror: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (avs_read_i && !avs_waitrequest_o && avs_address_i == idx_addr(IDX_IO_LIMIT))
        |-> (avs_readdata_o[IO_CAP_BIT] == io_width_capability) && (avs_readdata_o[3:1] == 3'h0))
        else $error("io limit bit 0 does not mirror capability");

    chk_mpoison_gated: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(master_poison_flag) |-> $past(parity_error_response_enable))
        else $error("master poison set with parity response disabled");

    chk_mpoison_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (parity_error_response_enable && (sec_poison_cpl_i || sec_poison_wr_i)) |=> master_poison_flag)
        else $error("master poison not set on poisoned traffic");

    chk_rse_gated: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(received_system_error_flag) |-> $past(system_error_report_enable))
        else $error("system error flag set with reporting disabled");

    chk_rse_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (system_error_report_enable && (sec_err_fatal_i || sec_err_nonfatal_i)) |=> received_system_error_flag)
        else $error("system error flag not set on error message");

    chk_dpe_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        sec_poison_tlp_i |=> detected_poison_flag)
        else $error("detected poison not set");

    chk_status_zero_bits: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (avs_read_i && !avs_waitrequest_o && avs_address_i == idx_addr(IDX_SEC_STATUS))
        |-> (avs_readdata_o[13:9] == 5'h00) && (avs_readdata_o[7:0] == 8'h00))
        else $error("secondary status fixed bits not zero");

    chk_io_forward: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (io_addr_i[31:16] == IO_UPPER_ZERO && io_addr_i[15:12] >= io_window_base
         && io_addr_i[15:12] <= io_window_limit) |=> io_fwd_o)
        else $error("io address in window not forwarded");

    chk_mem_forward: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (mem_addr_i[31:20] < memory_window_base || mem_addr_i[31:20] > memory_window_limit) |=> !mem_fwd_o)
        else $error("memory address outside window forwarded");

    chk_membase_reset: assert property (@(posedge mclk_i)
        $rose(arst_n_i) |-> memory_window_base == MEM_BASE_RST && io_window_limit == IO_LIMIT_RST)
        else $error("window registers left reset with wrong value");

    chk_wait_one_cycle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ($rose(req) || (req && $past(!avs_waitrequest_o))) |-> avs_waitrequest_o ##1 (!avs_waitrequest_o || !req))
        else $error("waitrequest not released after one cycle");
endmodule

// file: rtl/bws_win_cmp.sv
// Registered inclusive window compare
`timescale 1ns/1ns
module bws_win_cmp
    import bws_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    // Window
    bws_win_if.cmp    win
);
    logic hit;
    logic next_hit;

    always_comb begin
        next_hit = (win.addr >= win.low) && (win.addr <= win.high);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit <= 1'b0;
        end else begin
            hit <= next_hit;
        end
    end

    assign win.hit = hit;

    chk_closed_window: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ($past(win.low) > $past(win.high)) |-> !hit)
        else $error("window hit while base above limit");
endmodule

// file: rtl/bws_win_if.sv
// Window bounds and hit flag between the register bank and a comparator
`timescale 1ns/1ns
interface bws_win_if;
    logic [31:0] addr;
    logic [31:0] low;
    logic [31:0] high;
    logic        hit;

    modport cmp   (input addr, input low, input high, output hit);
    modport owner (output addr, output low, output high, input hit);
endinterface
